// file: core/wdt_top.sv
// Watchdog timer with keyed feed sequence and Avalon-MM register slave
//
// Behaviour
// R1: 13-bit prescaler feeds 8-bit main counter through one of its upper taps.
// R2: Prescaler advances on the shared timer tick.
// R3: Select codes 0..7 decrement once per 32..4096 timer ticks.
// R4: Tick at count zero raises underflow and reloads from the reload value.
// R5: Reload accepts 00..ff; every autoload clears the prescaler.
// R6: Underflow forces a system reset.
// R7: Timeout equals tick period times divisor times reload plus one.
// R8: Software cannot write the main counter; only autoload loads it.
// R9: Key a5 then 5a on consecutive accesses performs an autoload.
// R10: Good first key followed by bad second key resets at once.
// R11: Any other access between the two keys resets at once.
// R12: Control writes stay pending until a valid feed.
// R13: Clearing run then feeding halts counting.
// R14: Watchdog runs after every reset.
// R15: External reset sets run, reload 00, clears flag and prescaler, top tap.
// R16: Reset values give a 1 x 4096 period timeout.
// R17: Underflow during external reset leaves the timeout flag clear.
// R18: Software should mask interrupts while feeding and feed in time.
// R19: Timeout flag is set by underflow and stays readable afterwards.
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module wdt_top
	import wdt_pkg::*;
#(
	parameter int PRE_W = 13,
	parameter int CNT_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_timer_tick_source,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_sys_reset,
	output logic o_irq
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Low prescaler bits that must be all ones for a decrement
	function automatic logic [PRE_W-1:0] tap_mask(input logic [2:0] sel);
		logic [PRE_W:0] one;
		one = '0;
		one[`WDT_SEL_BASE_LOG2 + 32'(sel)] = 1'b1;
		tap_mask = PRE_W'(one - 1'b1);
	endfunction : tap_mask

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------

	// One wait cycle per access keeps read data registered
	logic bus_ack;
	logic bus_req;
	logic acc;
	logic wr;
	logic wr_lo;

	assign bus_req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = bus_req & ~bus_ack;
	assign acc = bus_req & bus_ack;
	assign wr = acc & i_avs_write;
	assign wr_lo = wr & i_avs_byteenable[0];

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------

	wdt_ctrl_t ctrl_pend;
	wdt_ctrl_t ctrl_live;
	logic [CNT_W-1:0] watchdog_reload_value;
	logic [PRE_W-1:0] presc;
	logic [CNT_W-1:0] cnt;
	wdt_feed_t feed_st;
	wdt_evt_t irq_stat;
	wdt_evt_t irq_mask;
	logic dec;
	logic underflow;
	logic feed_ok;
	logic feed_fault;
	logic autoload;
	wdt_evt_t evt;
	wdt_evt_t clr;

	// ----------------------------------------------------------------
	// Feed sequence
	// ----------------------------------------------------------------

	logic key1_hit;
	logic at_feed2;

	assign key1_hit = wr_lo && i_avs_address == `WDT_OFS_FEED1
		&& i_avs_writedata[7:0] == `WDT_KEY_FIRST;
	assign at_feed2 = wr && i_avs_address == `WDT_OFS_FEED2;

	// The access right after the first key decides the outcome
	assign feed_ok = feed_st == WDT_FEED_ARMED && at_feed2
		&& i_avs_byteenable[0]
		&& i_avs_writedata[7:0] == `WDT_KEY_SECOND; // [R9]
	assign feed_fault = feed_st == WDT_FEED_ARMED && acc
		&& !feed_ok; // [R10] [R11]

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			feed_st <= WDT_FEED_IDLE;
		end else if (acc) begin
			unique case (feed_st)
				WDT_FEED_IDLE: begin
					if (key1_hit) begin
						feed_st <= WDT_FEED_ARMED;
					end
				end
				WDT_FEED_ARMED: begin
					feed_st <= WDT_FEED_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control and reload registers
	// ----------------------------------------------------------------

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_pend <= '{run: `WDT_RST_RUN, div_sel: `WDT_RST_SEL}; // [R15]
		end else if (wr_lo && i_avs_address == `WDT_OFS_CTRL) begin
			ctrl_pend.run <= i_avs_writedata[`WDT_CTRL_RUN_BIT];
			ctrl_pend.div_sel <= i_avs_writedata[`WDT_CTRL_SEL_LSB +: 3];
		end
	end

	// Only a completed feed moves the pending control into use
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_live <= '{run: `WDT_RST_RUN, div_sel: `WDT_RST_SEL}; // [R14] [R16]
		end else if (feed_ok) begin
			ctrl_live <= ctrl_pend; // [R12] [R13]
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			watchdog_reload_value <= `WDT_RST_RELOAD; // [R15]
		end else if (wr_lo && i_avs_address == `WDT_OFS_RELOAD) begin
			watchdog_reload_value <= i_avs_writedata[CNT_W-1:0]; // [R5]
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and main counter
	// ----------------------------------------------------------------

	assign dec = ctrl_live.run && i_timer_tick_source
		&& (presc & tap_mask(ctrl_live.div_sel))
		== tap_mask(ctrl_live.div_sel); // [R1] [R3] [R7]
	assign underflow = dec && cnt == '0; // [R4]
	assign autoload = underflow | feed_ok;

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			presc <= '0; // [R15]
		end else if (autoload) begin
			presc <= '0; // [R5]
		end else if (ctrl_live.run && i_timer_tick_source) begin
			presc <= presc + 1'b1; // [R2]
		end
	end

	// Reset leaves the counter as if autoloaded from 00
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt <= `WDT_RST_RELOAD; // [R15]
		end else if (autoload) begin
			cnt <= watchdog_reload_value; // [R4] [R8] [R9]
		end else if (dec) begin
			cnt <= cnt - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// System reset request
	// ----------------------------------------------------------------

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sys_reset <= 1'b0;
		end else begin
			o_sys_reset <= underflow | feed_fault; // [R6] [R10] [R11]
		end
	end

	// ----------------------------------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------------------------------

	assign evt = '{feed_ok: feed_ok, feed_fault: feed_fault,
		timeout: underflow};
	assign clr = (wr_lo && i_avs_address == `WDT_OFS_STATUS)
		? wdt_evt_t'(i_avs_writedata[2:0]) : '0;

	// Set beats clear so no event is lost in the clearing cycle
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat <= '0; // [R17]
		end else begin
			irq_stat <= (irq_stat & ~clr) | evt; // [R19]
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_mask <= '0;
		end else if (wr_lo && i_avs_address == `WDT_OFS_MASK) begin
			irq_mask <= wdt_evt_t'(i_avs_writedata[2:0]);
		end
	end

	assign o_irq = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Unmapped and write-only addresses read as zero
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read && !bus_ack) begin
			o_avs_readdata <= '0;
			unique case (i_avs_address)
				`WDT_OFS_CTRL: begin
					o_avs_readdata[`WDT_CTRL_SEL_LSB +: 3] <= ctrl_pend.div_sel;
					o_avs_readdata[`WDT_CTRL_RUN_BIT] <= ctrl_pend.run;
					o_avs_readdata[`WDT_CTRL_LIVE_LSB +: 4] <= ctrl_live;
				end
				`WDT_OFS_RELOAD: begin
					o_avs_readdata[CNT_W-1:0] <= watchdog_reload_value;
				end
				`WDT_OFS_COUNT: begin
					o_avs_readdata[CNT_W-1:0] <= cnt;
				end
				`WDT_OFS_STATUS: begin
					o_avs_readdata[2:0] <= irq_stat;
				end
				`WDT_OFS_MASK: begin
					o_avs_readdata[2:0] <= irq_mask;
				end
				default: begin
					o_avs_readdata <= '0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	AST_UNDERFLOW_RELOAD: assert property ( // [R4]
		@(posedge i_mclk) disable iff (!i_arst_n)
		underflow |=> cnt == $past(watchdog_reload_value))
		else $error("underflow did not reload the counter");

	AST_PRESC_CLEAR: assert property ( // [R5]
		@(posedge i_mclk) disable iff (!i_arst_n)
		autoload |=> presc == '0)
		else $error("autoload did not clear the prescaler");

	AST_UNDERFLOW_RESET: assert property ( // [R6]
		@(posedge i_mclk) disable iff (!i_arst_n)
		underflow |=> o_sys_reset && irq_stat.timeout)
		else $error("underflow gave no reset or flag");

	// Feed and underflow may share a cycle; then a reset pulse is due
	AST_FEED_LOAD: assert property ( // [R9]
		@(posedge i_mclk) disable iff (!i_arst_n)
		feed_ok |=> cnt == $past(watchdog_reload_value)
		&& ctrl_live == $past(ctrl_pend)
		&& o_sys_reset == $past(underflow))
		else $error("valid feed did not autoload");

	AST_BAD_SECOND_KEY: assert property ( // [R10]
		@(posedge i_mclk) disable iff (!i_arst_n)
		feed_st == WDT_FEED_ARMED && at_feed2
		&& i_avs_writedata[7:0] != `WDT_KEY_SECOND |=> o_sys_reset)
		else $error("wrong second key did not reset");

	AST_INTERVENING: assert property ( // [R11]
		@(posedge i_mclk) disable iff (!i_arst_n)
		feed_st == WDT_FEED_ARMED && acc && !at_feed2
		|=> o_sys_reset && feed_st == WDT_FEED_IDLE)
		else $error("intervening access did not reset");

	AST_CTRL_PENDING: assert property ( // [R12]
		@(posedge i_mclk) disable iff (!i_arst_n)
		!feed_ok |=> ctrl_live == $past(ctrl_live))
		else $error("control changed without a feed");

	AST_STOPPED: assert property ( // [R13]
		@(posedge i_mclk) disable iff (!i_arst_n)
		!ctrl_live.run && !feed_ok |=> $stable(cnt) && $stable(presc))
		else $error("stopped watchdog kept counting");

	AST_NO_DIRECT_LOAD: assert property ( // [R8]
		@(posedge i_mclk) disable iff (!i_arst_n)
		wr && i_avs_address == `WDT_OFS_COUNT && !dec && !feed_ok
		|=> $stable(cnt))
		else $error("counter was written directly");

	AST_DEC_RATE: assert property ( // [R3]
		@(posedge i_mclk) disable iff (!i_arst_n)
		dec && !autoload |=> presc[`WDT_SEL_BASE_LOG2-1:0] == '0)
		else $error("decrement off the tap boundary");

	AST_DEC_STEP: assert property ( // [R1]
		@(posedge i_mclk) disable iff (!i_arst_n)
		dec && cnt != '0 && !feed_ok |=> cnt == $past(cnt) - 1'b1)
		else $error("decrement did not lower the counter by one");

	AST_PRESC_STEP: assert property ( // [R2]
		@(posedge i_mclk) disable iff (!i_arst_n)
		ctrl_live.run && i_timer_tick_source && !autoload
		|=> presc == $past(presc) + 1'b1)
		else $error("prescaler missed a timer tick");

	AST_PRESC_HOLD: assert property ( // [R2]
		@(posedge i_mclk) disable iff (!i_arst_n)
		!i_timer_tick_source && !autoload |=> $stable(presc))
		else $error("prescaler moved without a timer tick");

	AST_KEY_ARMS: assert property ( // [R9]
		@(posedge i_mclk) disable iff (!i_arst_n)
		key1_hit && feed_st == WDT_FEED_IDLE |=> feed_st == WDT_FEED_ARMED)
		else $error("first key did not arm the feed");

	AST_RESET_CAUSE: assert property ( // [R6] [R10] [R11]
		@(posedge i_mclk) disable iff (!i_arst_n)
		o_sys_reset |-> $past(underflow) || $past(feed_fault))
		else $error("system reset without a cause");

	AST_FLAG_STICKY: assert property ( // [R19]
		@(posedge i_mclk) disable iff (!i_arst_n)
		irq_stat.timeout && !clr.timeout |=> irq_stat.timeout)
		else $error("timeout flag dropped without a clear");

	// No disable here: it looks at the very edge that ends reset
	AST_RESET_STATE: assert property ( // [R14] [R15] [R16] [R17]
		@(posedge i_mclk)
		$rose(i_arst_n) |-> ctrl_live.run == `WDT_RST_RUN
		&& ctrl_live.div_sel == `WDT_RST_SEL
		&& watchdog_reload_value == `WDT_RST_RELOAD
		&& cnt == `WDT_RST_RELOAD && presc == '0 && irq_stat == '0)
		else $error("reset left a wrong watchdog state");

endmodule : wdt_top

`default_nettype wire

// file: core/wdt_map.svh
// Register offsets, field positions, reset values and keys of the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WDT_OFS_CTRL 5'h00
`define WDT_OFS_RELOAD 5'h04
`define WDT_OFS_FEED1 5'h08
`define WDT_OFS_FEED2 5'h0c
`define WDT_OFS_COUNT 5'h10
`define WDT_OFS_STATUS 5'h14
`define WDT_OFS_MASK 5'h18

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define WDT_CTRL_SEL_LSB 0
`define WDT_CTRL_RUN_BIT 4
`define WDT_CTRL_LIVE_LSB 8
`define WDT_ST_TIMEOUT 0
`define WDT_ST_FEED_FAULT 1
`define WDT_ST_FEED_OK 2
`define WDT_RST_RUN 1'h1
`define WDT_RST_SEL 3'h7
`define WDT_RST_RELOAD 8'h00
`define WDT_KEY_FIRST 8'ha5
`define WDT_KEY_SECOND 8'h5a
`define WDT_SEL_BASE_LOG2 5

`endif

// file: core/wdt_pkg.sv
// Types shared by the watchdog design
`default_nettype none
package wdt_pkg;

	// Control word: run flag and divisor select
	typedef struct packed {
		logic run;
		logic [2:0] div_sel;
	} wdt_ctrl_t;

	// Feed sequence progress
	typedef enum logic {
		WDT_FEED_IDLE,
		WDT_FEED_ARMED
	} wdt_feed_t;

	// Events that set sticky status bits
	typedef struct packed {
		logic feed_ok;
		logic feed_fault;
		logic timeout;
	} wdt_evt_t;

endpackage : wdt_pkg
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the watchdog and its register slave
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module tb import wdt_pkg::*;;
	localparam logic [4:0] CT = `WDT_OFS_CTRL;
	localparam logic [4:0] RL = `WDT_OFS_RELOAD;
	localparam logic [4:0] F1 = `WDT_OFS_FEED1;
	localparam logic [4:0] F2 = `WDT_OFS_FEED2;
	localparam logic [4:0] CN = `WDT_OFS_COUNT;
	localparam logic [4:0] ST = `WDT_OFS_STATUS;
	localparam logic [4:0] MK = `WDT_OFS_MASK;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic tick = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic wrq;
	logic srst;
	logic irq;
	logic [31:0] q;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;

	wdt_top i_dut (.i_mclk(clk), .i_arst_n(rst_n),
		.i_timer_tick_source(tick), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wrq), .o_sys_reset(srst), .o_irq(irq));

	initial forever #5 clk = ~clk;

	// ----------------------------------------------------------------
	// Run control and compares
	// ----------------------------------------------------------------
	// Ceiling sits well above the longest expected run of about 42k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			close_out();
		end
	end

	task close_out;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task chk_t(input int g, input int lo, input int hi);
		num_checks++;
		if (g < lo || g > hi) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, lo);
		end
	endtask : chk_t

	// ----------------------------------------------------------------
	// Bus access: hold until waitrequest is seen low, then release
	// ----------------------------------------------------------------
	task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			k++;
			if (k > 50) begin
				errors++;
				close_out();
			end
		end while (wrq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : acc

	// Interrupt follows flops that move at the access edge; look later
	task chk_irq(input logic e);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : chk_irq

	task feed;
		acc(1'b1, F1, 32'ha5);
		acc(1'b1, F2, 32'h5a);
	endtask : feed

	// Cycles until the reset pulse, or lim if none comes
	task meas(input int lim, output int c);
		c = 0;
		@(negedge clk);
		while (srst !== 1'b1 && c < lim) begin
			@(negedge clk);
			c++;
		end
	endtask : meas

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		meas(9000, n);
		chk_t(n, 4094, 4100);
		acc(1'b0, CT, 32'h0);
		chk(q & 32'h0f00, 32'h0f00);
		acc(1'b0, RL, 32'h0);
		chk(q, 32'h0);
		acc(1'b0, ST, 32'h0);
		chk(q & 32'h1, 32'h1);
		$display("test reset defaults done");
		acc(1'b1, CT, 32'h0);
		acc(1'b0, CT, 32'h0);
		chk(q & 32'h0f1f, 32'h0f00);
		feed();
		acc(1'b0, CT, 32'h0);
		chk(q & 32'h0f00, 32'h0);
		$display("test pending control done");
		for (int s = 0; s < 8; s++) begin
			acc(1'b1, RL, 32'h1);
			acc(1'b1, CT, 32'h10 | s);
			feed();
			meas(9000, n);
			chk_t(n, (64 << s) - 2, (64 << s) + 3);
		end
		acc(1'b1, RL, 32'hff);
		acc(1'b1, CT, 32'h10);
		feed();
		meas(9000, n);
		chk_t(n, 8190, 8195);
		$display("test divisors done");
		acc(1'b1, MK, 32'h0);
		acc(1'b1, ST, 32'h7);
		chk_irq(1'b0);
		acc(1'b1, MK, 32'h1);
		meas(9000, n);
		acc(1'b0, ST, 32'h0);
		chk(q & 32'h1, 32'h1);
		chk_irq(1'b1);
		acc(1'b1, ST, 32'h1);
		chk_irq(1'b0);
		$display("test interrupt done");
		acc(1'b1, RL, 32'h1);
		acc(1'b1, CT, 32'h17);
		feed();
		acc(1'b1, CN, 32'h0);
		acc(1'b0, CN, 32'h0);
		chk(q, 32'h1);
		acc(1'b1, F1, 32'ha5);
		acc(1'b1, F2, 32'h5b);
		meas(20, n);
		chk_t(n, 0, 3);
		acc(1'b0, ST, 32'h0);
		chk(q & 32'h6, 32'h6);
		acc(1'b1, F1, 32'ha5);
		acc(1'b0, RL, 32'h0);
		meas(20, n);
		chk_t(n, 0, 3);
		$display("test feed faults done");
		acc(1'b1, CT, 32'h0);
		feed();
		meas(5000, n);
		chk_t(n, 5000, 5000);
		acc(1'b1, RL, 32'h0);
		acc(1'b1, CT, 32'h10);
		@(posedge clk);
		tick <= 1'b0;
		feed();
		meas(300, n);
		chk_t(n, 300, 300);
		@(posedge clk);
		tick <= 1'b1;
		meas(300, n);
		chk_t(n, 30, 36);
		$display("test stop and tick done");
		close_out();
	end

endmodule : tb
`default_nettype wire
